/* src/pims_pkg.sv */
// Package for the PHY interface mode select block: offsets, encodings, reset values
package pims_pkg;
  localparam int MODE_W = 3;
  typedef enum logic [2:0] {
    PIMS_RGMII_COPPER = 3'b000,
    PIMS_SGMII_COPPER = 3'b001,
    PIMS_RGMII_BX     = 3'b010,
    PIMS_RGMII_FX     = 3'b011,
    PIMS_RGMII_SGMII  = 3'b100,
    PIMS_RSVD_5       = 3'b101,
    PIMS_RSVD_6       = 3'b110,
    PIMS_RSVD_7       = 3'b111
  } pims_mode_t;
  localparam logic [2:0] MODE_RST_SERDES = 3'h7;
  localparam logic [2:0] MODE_RST_PLAIN  = 3'h0;
  // Register byte offsets on APB
  localparam logic [11:0] OFF_MODE   = 12'h000;
  localparam logic [11:0] OFF_CTRL   = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  // Field positions
  localparam int CTRL_SGMII_AN_EN = 0;
  localparam int ST_LINK          = 0;
  localparam int ST_DUPLEX        = 1;
  localparam int ST_SPEED_LO      = 2;
  localparam int ST_SYS_SGMII     = 4;
  localparam int ST_VALID         = 5;
  localparam logic [1:0] SPEED_1000 = 2'h2;
endpackage : pims_pkg

/* src/pims_route.sv */
// Interface pairing decoder: maps a mode to routes, power-downs and SGMII role
`timescale 1ns/1ps
`default_nettype none
module pims_route (
  input  wire logic [2:0] mode,
  output logic            valid,
  output logic            sgmii_sys,
  output logic            sgmii_media,
  output logic            pd_copper,
  output logic            pd_rgmii,
  output logic            pd_serdes
);
  always_comb begin
    valid       = 1'b1;
    sgmii_sys   = 1'b0;
    sgmii_media = 1'b0;
    pd_copper   = 1'b1;
    pd_rgmii    = 1'b1;
    pd_serdes   = 1'b1;
    case (pims_pkg::pims_mode_t'(mode))
      pims_pkg::PIMS_RGMII_COPPER: begin
        pd_copper = 1'b0;
        pd_rgmii  = 1'b0;
      end
      pims_pkg::PIMS_SGMII_COPPER: begin
        pd_copper = 1'b0;
        pd_serdes = 1'b0;
        sgmii_sys = 1'b1;
      end
      pims_pkg::PIMS_RGMII_BX, pims_pkg::PIMS_RGMII_FX: begin
        pd_rgmii  = 1'b0;
        pd_serdes = 1'b0;
      end
      pims_pkg::PIMS_RGMII_SGMII: begin
        pd_rgmii    = 1'b0;
        pd_serdes   = 1'b0;
        sgmii_media = 1'b1;
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end
endmodule // pims_route
`default_nettype wire

/* src/pims_top.sv */
// PHY interface mode select: APB registers, pairing, role and mirroring control
// Functional notes
// - Decode three-bit mode into five pairings
// - SERDES variant resets mode to reserved 111
// - Non-SERDES variant resets mode to 000
// - Copper media, RGMII system, SGMII per mode
// - SGMII system runs PHY-side auto-negotiation
// - System side mirrors media speed and duplex
// - SGMII media runs MAC-side auto-negotiation
// - Media conversion: mode 001, SGMII AN off
// - Forward paired interfaces, power down third
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pims_top #(
  parameter bit HAS_SERDES = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        media_link,
  input  wire logic        media_duplex,
  input  wire logic [1:0]  media_speed,
  output logic             fwd_en,
  output logic             route_copper,
  output logic             route_rgmii,
  output logic             route_serdes,
  output logic             pd_copper,
  output logic             pd_rgmii,
  output logic             pd_serdes,
  output logic             an_phy_side,
  output logic             an_mac_side,
  output logic             sys_duplex,
  output logic      [1:0]  sys_speed
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] st1;
  logic [3:0] st2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st1 <= 4'h0;
      st2 <= 4'h0;
    end else begin
      st1 <= {media_speed, media_duplex, media_link};
      st2 <= st1;
    end
  end
  logic       lnk;
  logic       dup;
  logic [1:0] spd;
  assign lnk = st2[0];
  assign dup = st2[1];
  assign spd = st2[3:2];

  // ==========================================================
  // Registers
  logic [2:0] mode;
  logic       an_en;
  logic       wr_acc;
  logic       mapped;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == pims_pkg::OFF_MODE) || (paddr == pims_pkg::OFF_CTRL)
                  || (paddr == pims_pkg::OFF_STATUS);

  // Reset value depends on the variant
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= HAS_SERDES ? pims_pkg::MODE_RST_SERDES : pims_pkg::MODE_RST_PLAIN;
    end else if (wr_acc && paddr == pims_pkg::OFF_MODE) begin
      mode <= pwdata[2:0];
    end
  end

  // SGMII auto-negotiation enable; cleared for copper to 1000BASE-X conversion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_en <= 1'b1;
    end else if (wr_acc && paddr == pims_pkg::OFF_CTRL) begin
      an_en <= pwdata[pims_pkg::CTRL_SGMII_AN_EN];
    end
  end

  // ==========================================================
  // Pairing decode
  logic v;
  logic s_sys;
  logic s_med;
  logic p_cu;
  logic p_rg;
  logic p_sd;
  pims_route u_route (
    .mode        (mode),
    .valid       (v),
    .sgmii_sys   (s_sys),
    .sgmii_media (s_med),
    .pd_copper   (p_cu),
    .pd_rgmii    (p_rg),
    .pd_serdes   (p_sd)
  );

  // Power-down is automatic; software power-down bits are not needed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_copper <= 1'b1;
      pd_rgmii  <= 1'b1;
      pd_serdes <= 1'b1;
    end else begin
      pd_copper <= p_cu;
      pd_rgmii  <= p_rg;
      pd_serdes <= p_sd;
    end
  end

  // Forward only while link is up and the mode is valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_en       <= 1'b0;
      route_copper <= 1'b0;
      route_rgmii  <= 1'b0;
      route_serdes <= 1'b0;
    end else begin
      fwd_en       <= v && lnk;
      route_copper <= v && lnk && !p_cu;
      route_rgmii  <= v && lnk && !p_rg;
      route_serdes <= v && lnk && !p_sd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_phy_side <= 1'b0;
      an_mac_side <= 1'b0;
    end else begin
      an_phy_side <= s_sys && an_en;
      an_mac_side <= s_med && an_en;
    end
  end

  // Mirror media result; held at last value while link is down
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_duplex <= 1'b0;
      sys_speed  <= 2'h0;
    end else if (lnk) begin
      sys_duplex <= dup;
      sys_speed  <= spd;
    end
  end

  // ==========================================================
  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          pims_pkg::OFF_MODE: prdata <= {29'h0, mode};
          pims_pkg::OFF_CTRL: prdata <= {31'h0, an_en};
          pims_pkg::OFF_STATUS: begin
            prdata[pims_pkg::ST_LINK]                       <= lnk;
            prdata[pims_pkg::ST_DUPLEX]                     <= sys_duplex;
            prdata[pims_pkg::ST_SPEED_LO+1:pims_pkg::ST_SPEED_LO] <= sys_speed;
            prdata[pims_pkg::ST_SYS_SGMII]                  <= s_sys;
            prdata[pims_pkg::ST_VALID]                      <= v;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_rsvd_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !v |=> !fwd_en && !route_copper && !route_rgmii && !route_serdes)
    else $error("forwarding under reserved mode");
  chk_third_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    v |=> ($countones({pd_copper, pd_rgmii, pd_serdes}) == 1))
    else $error("unused interface not powered down");
  chk_mirror_dup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lnk |=> sys_duplex == $past(dup) && sys_speed == $past(spd))
    else $error("system side not mirroring media");
  chk_phy_an: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == pims_pkg::PIMS_SGMII_COPPER && an_en) |=> an_phy_side && !an_mac_side)
    else $error("phy side negotiation missing");
  chk_mac_an: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == pims_pkg::PIMS_RGMII_SGMII && an_en) |=> an_mac_side && !an_phy_side)
    else $error("mac side negotiation missing");
  chk_an_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !an_en |=> !an_phy_side && !an_mac_side)
    else $error("negotiation running while disabled");
  chk_copper_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (v && mode != pims_pkg::PIMS_RGMII_BX && mode != pims_pkg::PIMS_RGMII_FX
     && mode != pims_pkg::PIMS_RGMII_SGMII) |=> !pd_copper)
    else $error("copper media powered down");
  chk_fwd_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (v && lnk) [*2] |-> fwd_en)
    else $error("no forwarding with link up");
  cov_sgmii_sys: cover property (@(posedge ref_clk) disable iff (!rst_n) an_phy_side && fwd_en);
  cov_sgmii_med: cover property (@(posedge ref_clk) disable iff (!rst_n) an_mac_side && fwd_en);
  cov_rsvd_to_ok: cover property (@(posedge ref_clk) disable iff (!rst_n) !v ##1 v);
endmodule // pims_top
`default_nettype wire

/* testbench/pims_media_peer.sv */
// Media-side link partner model: resolves link, duplex and speed
`timescale 1ns/1ps
`default_nettype none
module pims_media_peer (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic       want_link,
  input  wire logic       want_duplex,
  input  wire logic [1:0] want_speed,
  output logic            media_link,
  output logic            media_duplex,
  output logic      [1:0] media_speed
);
  int unsigned wait_cnt;
  initial begin
    media_link   = 1'b0;
    media_duplex = 1'b0;
    media_speed  = 2'h0;
    wait_cnt     = 0;
  end
  // ==========================================================
  // Resolution delay
  // Slow partner takes several cycles, like a real negotiation
  always @(posedge ref_clk) begin
    if ({want_link, want_duplex, want_speed} == {media_link, media_duplex, media_speed}) begin
      wait_cnt <= 0;
    end else if (wait_cnt >= (slow ? 5 : 0)) begin
      media_link   <= want_link;
      media_duplex <= want_duplex;
      media_speed  <= want_speed;
      wait_cnt     <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule // pims_media_peer
`default_nettype wire

/* testbench/pims_top_tb.sv */
// Self-checking bench for the interface mode select block
`timescale 1ns/1ps
`default_nettype none
module pims_top_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, media_link, media_duplex, fwd_en, route_copper, route_rgmii;
  logic route_serdes, pd_copper, pd_rgmii, pd_serdes, an_phy_side, an_mac_side, sys_duplex;
  logic [1:0] media_speed, sys_speed, want_speed = 2'h0;
  logic slow = 1'b0, want_link = 1'b0, want_duplex = 1'b0;
  logic pl_fwd, pl_rc, pl_rr, pl_rs, pl_pdc, pl_pdr, pl_pds;
  logic [32:0] exp_q[$];
  int err_total = 0, cmp_count = 0, seed = 90;
  always #12.5 ref_clk = ~ref_clk;
  pims_top #(.HAS_SERDES(1'b1)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .media_link(media_link), .media_duplex(media_duplex),
    .media_speed(media_speed), .fwd_en(fwd_en), .route_copper(route_copper),
    .route_rgmii(route_rgmii), .route_serdes(route_serdes), .pd_copper(pd_copper),
    .pd_rgmii(pd_rgmii), .pd_serdes(pd_serdes), .an_phy_side(an_phy_side),
    .an_mac_side(an_mac_side), .sys_duplex(sys_duplex), .sys_speed(sys_speed));
  // Variant without SERDES shares the bus; only its pairing outputs are watched
  pims_top #(.HAS_SERDES(1'b0)) i_dut_plain (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .media_link(media_link), .media_duplex(media_duplex),
    .media_speed(media_speed), .fwd_en(pl_fwd), .route_copper(pl_rc), .route_rgmii(pl_rr),
    .route_serdes(pl_rs), .pd_copper(pl_pdc), .pd_rgmii(pl_pdr), .pd_serdes(pl_pds),
    .an_phy_side(), .an_mac_side(), .sys_duplex(), .sys_speed());
  pims_media_peer i_peer (.ref_clk(ref_clk), .slow(slow), .want_link(want_link),
    .want_duplex(want_duplex), .want_speed(want_speed), .media_link(media_link),
    .media_duplex(media_duplex), .media_speed(media_speed));
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // APB master; the expected answer is queued before the request
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    exp_q.push_back(exp);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      cmp({32'h0, pready}, 33'h1);
      void'(exp_q.pop_back());
    end
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so that back-to-back calls never assign psel twice in one time step
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) cmp({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  end
  function automatic logic [8:0] exp_out(input logic [2:0] m, input logic an);
    case (m)
      3'h0: exp_out = 9'b1_110_001_00;
      3'h1: exp_out = {7'b1_101_010, an, 1'b0};
      3'h2, 3'h3: exp_out = 9'b1_011_100_00;
      3'h4: exp_out = {8'b1_011_100_0, an};
      default: exp_out = 9'b0_000_111_00;
    endcase
  endfunction
  task automatic chk_out(input logic [2:0] m, input logic an);
    cmp({24'h0, fwd_en, route_copper, route_rgmii, route_serdes, pd_copper, pd_rgmii,
         pd_serdes, an_phy_side, an_mac_side}, {24'h0, exp_out(m, an)});
  endtask
  initial begin
    #(25 * 20000);
    err_total++;
    final_report();
  end
  initial begin
    logic [31:0] r;
    want_link <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, pims_pkg::OFF_MODE, 32'h0, {1'b0, 32'h7});
    chk_out(3'h7, 1'b1);
    cmp({26'h0, pl_fwd, pl_rc, pl_rr, pl_rs, pl_pdc, pl_pdr, pl_pds}, {26'h0, 7'b1_110_001});
    for (int m = 0; m < 8; m++) begin
      r = $random(seed);
      apb(1'b1, pims_pkg::OFF_MODE, {r[31:3], m[2:0]}, 33'h0);
      apb(1'b0, pims_pkg::OFF_MODE, 32'h0, {30'h0, m[2:0]});
      chk_out(m[2:0], 1'b1);
    end
    // Valid mode so that the status word reports a valid pairing
    apb(1'b1, pims_pkg::OFF_MODE, {29'h0, pims_pkg::PIMS_RGMII_BX}, 33'h0);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      slow <= r[0]; want_duplex <= r[1]; want_speed <= r[3:2];
      repeat (12) @(posedge ref_clk);
      cmp({30'h0, sys_speed, sys_duplex}, {30'h0, r[3:2], r[1]});
      apb(1'b0, pims_pkg::OFF_STATUS, 32'h0, {27'h0, 2'b10, r[3:1], 1'b1});
    end
    want_link <= 1'b0; want_speed <= ~want_speed;
    repeat (12) @(posedge ref_clk);
    cmp({31'h0, fwd_en, route_serdes}, 33'h0);
    cmp({31'h0, sys_speed}, {31'h0, ~want_speed});
    want_link <= 1'b1;
    apb(1'b1, pims_pkg::OFF_MODE, 32'h1, 33'h0);
    apb(1'b1, pims_pkg::OFF_CTRL, 32'h0, 33'h0);
    apb(1'b0, pims_pkg::OFF_CTRL, 32'h0, 33'h0);
    repeat (12) @(posedge ref_clk);
    chk_out(3'h1, 1'b0);
    apb(1'b1, 12'h00C, 32'h5, {1'b1, 32'h0});
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    apb(1'b0, pims_pkg::OFF_MODE, 32'h0, 33'h1);
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule // pims_top_tb
`default_nettype wire
